// *** lia_ack_builder.sv ***
`timescale 1ns/1ps
// Function
// R1: low-complexity node emits this layout, frame type bits 3:2 equal 01.
// R2: reserved bits 5:4, 28:26, 61:30 sent zero and ignored when parsed.
// R3: bits 11:6 carry six low bits of requester node identifier.
// R4: bits 19:12 carry the acknowledged llc frame sequence unchanged.
// R5: bit 20 set when an incoming multi-segment unit cannot be processed.
// R6: bit 21 is 1 for error-free unit, 0 for errored unit; here a refused error-free unit also gets 0.
// R7: far end reads ack bit only when unable_to_comply is zero.
// R8: bits 25:22 carry the partial parameter recommendation.
// R9: bit 29 is 1 when a parameter change is recommended, else 0.
// R10: with ack, flag 1 means snr well above need.
// R11: with nack, flag 1 means snr well below need.
// R12: snr estimation method is free; a margin comparator is used.
// R13: far end matches node tag plus sequence to its frame.
// R14: far end resends refused units in single-segment mode.
// R15: missing recommendation gives no-change, real report on next source frame.
// R16: refusals still carry correct node tag and sequence.
module lia_ack_builder #(
  parameter int NODE_IDENTIFIER_W = lia_pkg::NODE_IDENTIFIER_W,
  parameter int SNR_W = lia_pkg::SNR_W
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // receive path result
  input  wire logic i_rx_done,
  output logic o_rx_ready,
  input  wire logic [NODE_IDENTIFIER_W-1:0] i_rx_node_identifier,
  input  wire logic [lia_pkg::SEQ_W-1:0] i_rx_llc_seq,
  input  wire logic i_rx_err,
  input  wire logic i_rx_multi_seg,
  input  wire logic i_rx_tp_req,
  input  wire logic i_rx_cur_rscw,
  input  wire logic i_rx_cur_intm,
  input  wire logic [SNR_W-1:0] i_rx_snr,
  input  wire logic [SNR_W-1:0] i_rx_snr_need,
  // recommendation from the parameter estimator
  input  wire logic i_rec_valid,
  input  wire logic [lia_pkg::TPR_W-1:0] i_rec_value,
  // built field towards the header transmitter
  output logic o_ack_valid,
  input  wire logic i_ack_ready,
  output logic [lia_pkg::FIELD_W-1:0] o_ack_field,
  // field received from a remote node
  input  wire logic i_rem_valid,
  input  wire logic [lia_pkg::FIELD_W-1:0] i_rem_field,
  output logic o_rem_valid,
  output logic o_rem_type_ok,
  output logic [lia_pkg::TAG_W-1:0] o_rem_tag,
  output logic [lia_pkg::SEQ_W-1:0] o_rem_seq,
  output logic o_rem_utc,
  output logic o_rem_ack_ok,
  output logic o_rem_nack,
  output logic o_rem_lq,
  output logic [lia_pkg::TPR_W-1:0] o_rem_rec
);
  import lia_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    lia_state_e st;
    logic [FIELD_W-1:0] field;
    logic pend;
    logic [TAG_W-1:0] pend_tag;
    logic rem_valid;
    logic rem_type_ok;
    logic [TAG_W-1:0] rem_tag;
    logic [SEQ_W-1:0] rem_seq;
    logic rem_utc;
    logic rem_ack_ok;
    logic rem_nack;
    logic rem_lq;
    logic [TPR_W-1:0] rem_rec;
  } lia_state_s;

  lia_state_s s_reg;
  lia_state_s s_next;
  logic lq_change;
  logic take;
  logic ack_bit;
  logic [TAG_W-1:0] tag;
  logic [TPR_W-1:0] rec;

  // no-change repeats the transmitter's own rscw and interleave choice
  function automatic logic [TPR_W-1:0] no_change(input logic rscw,
                                                 input logic intm);
    logic [TPR_W-1:0] v;
    v = '0;
    v[TPR_RSCW] = rscw;
    v[TPR_REP_LSB +: 2] = REP_NO_CHANGE;
    v[TPR_INTM] = intm;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // link quality estimator
  // ---------------------------------------------------------------
  lia_link_quality #(
    .SNR_W(SNR_W),
    .MARGIN(SNR_MARGIN)
  ) u_lq (
    .i_snr(i_rx_snr),
    .i_snr_need(i_rx_snr_need),
    .i_ack(ack_bit),
    .o_change(lq_change)
  );

  // ---------------------------------------------------------------
  // builder and parser next state
  // ---------------------------------------------------------------
  // a refused unit is never acknowledged, so ack is cleared by an error or a refusal
  assign ack_bit = ~i_rx_err & ~i_rx_multi_seg; // R6
  assign tag = i_rx_node_identifier[TAG_W-1:0]; // R3
  assign take = i_rx_done & (s_reg.st == LIA_IDLE);
  // a new result is held off while the previous field waits for ready
  assign o_rx_ready = (s_reg.st == LIA_IDLE);

  always_comb begin
    rec = no_change(i_rx_cur_rscw, i_rx_cur_intm);
    if (i_rec_valid && (i_rx_tp_req || (s_reg.pend &&
        s_reg.pend_tag == tag))) begin
      rec = i_rec_value; // R8
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.rem_valid = 1'b0;
    case (s_reg.st)
      LIA_IDLE: begin
        if (i_rx_done) begin
          s_next.field = FIELD_RST; // R2
          s_next.field[FT_LSB +: 2] = FT_IMM_ACK; // R1
          s_next.field[TAG_LSB +: TAG_W] = tag; // R16
          s_next.field[SEQ_LSB +: SEQ_W] = i_rx_llc_seq; // R4
          s_next.field[UTC_BIT] = i_rx_multi_seg; // R5
          s_next.field[ACK_BIT] = ack_bit; // R6
          s_next.field[TPR_LSB +: TPR_W] = rec; // R15
          s_next.field[LQ_BIT] = lq_change; // R9 R12
          // report owed to this source if it asked and we could not answer
          if (i_rx_tp_req && !i_rec_valid) begin
            s_next.pend = 1'b1; // R15
            s_next.pend_tag = tag;
          end else if (s_reg.pend && s_reg.pend_tag == tag &&
                       i_rec_valid) begin
            s_next.pend = 1'b0;
          end
          s_next.st = LIA_HOLD;
        end
      end
      LIA_HOLD: begin
        if (i_ack_ready) begin
          s_next.st = LIA_IDLE;
        end
      end
      default: begin
        s_next.st = LIA_IDLE;
      end
    endcase
    // parse: reserved bits are not looked at
    if (i_rem_valid) begin
      s_next.rem_valid = 1'b1;
      s_next.rem_type_ok = (i_rem_field[FT_LSB +: 2] == FT_IMM_ACK);
      s_next.rem_tag = i_rem_field[TAG_LSB +: TAG_W]; // R13
      s_next.rem_seq = i_rem_field[SEQ_LSB +: SEQ_W];
      s_next.rem_utc = i_rem_field[UTC_BIT];
      s_next.rem_ack_ok = i_rem_field[ACK_BIT] & ~i_rem_field[UTC_BIT];
      s_next.rem_nack = ~i_rem_field[ACK_BIT] & ~i_rem_field[UTC_BIT];
      s_next.rem_lq = i_rem_field[LQ_BIT];
      s_next.rem_rec = i_rem_field[TPR_LSB +: TPR_W];
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_reg <= '{st: LIA_IDLE, field: FIELD_RST, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_ack_valid = (s_reg.st == LIA_HOLD);
  assign o_ack_field = s_reg.field;
  assign o_rem_valid = s_reg.rem_valid;
  assign o_rem_type_ok = s_reg.rem_type_ok;
  assign o_rem_tag = s_reg.rem_tag;
  assign o_rem_seq = s_reg.rem_seq;
  assign o_rem_utc = s_reg.rem_utc;
  assign o_rem_ack_ok = s_reg.rem_ack_ok;
  assign o_rem_nack = s_reg.rem_nack;
  assign o_rem_lq = s_reg.rem_lq;
  assign o_rem_rec = s_reg.rem_rec;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_frame_type: assert property ( // R1
    o_ack_valid |-> o_ack_field[FT_LSB +: 2] == FT_IMM_ACK)
    else $error("frame type not 01");
  a_reserved_zero: assert property ( // R2
    o_ack_valid |-> (o_ack_field[RSV_A_MSB:RSV_A_LSB] == '0) &&
      (o_ack_field[RSV_B_MSB:RSV_B_LSB] == '0) &&
      (o_ack_field[RSV_C_MSB:RSV_C_LSB] == '0) &&
      (o_ack_field[1:0] == '0))
    else $error("reserved bits not zero");
  a_tag_copy: assert property ( // R3
    take |=> o_ack_valid &&
      o_ack_field[TAG_LSB +: TAG_W] == $past(i_rx_node_identifier[TAG_W-1:0]))
    else $error("node tag wrong");
  a_seq_copy: assert property ( // R4
    take |=> o_ack_field[SEQ_LSB +: SEQ_W] == $past(i_rx_llc_seq))
    else $error("sequence wrong");
  a_utc_bit: assert property ( // R5
    take |=> o_ack_field[UTC_BIT] == $past(i_rx_multi_seg))
    else $error("unable flag wrong");
  a_ack_bit: assert property ( // R6
    take && !i_rx_multi_seg |=> o_ack_field[ACK_BIT] == !$past(i_rx_err))
    else $error("ack bit wrong");
  // judged from the snr inputs, so a broken estimator is caught here
  a_lq_flag: assert property ( // R9
    take |=> o_ack_field[LQ_BIT] == (o_ack_field[ACK_BIT] ?
      ({1'b0, $past(i_rx_snr)} >
        {1'b0, $past(i_rx_snr_need)} + {1'b0, SNR_MARGIN}) :
      ({1'b0, $past(i_rx_snr)} + {1'b0, SNR_MARGIN} <
        {1'b0, $past(i_rx_snr_need)})))
    else $error("link quality flag wrong");
  a_no_change_rec: assert property ( // R15
    take && !i_rec_valid |=> o_ack_field[TPR_LSB +: TPR_W] ==
      no_change($past(i_rx_cur_rscw), $past(i_rx_cur_intm)))
    else $error("no-change recommendation wrong");
  a_hold_field: assert property ( // field held stable until ready
    o_ack_valid && !i_ack_ready |=> o_ack_valid && $stable(o_ack_field))
    else $error("field changed while held");
  a_rem_qualify: assert property ( // R7
    i_rem_valid && i_rem_field[UTC_BIT] |=> o_rem_valid &&
      !o_rem_ack_ok && !o_rem_nack && o_rem_utc)
    else $error("ack used despite refusal");

  c_ack: cover property (take && !i_rx_err && !i_rx_multi_seg);
  c_nack_lq: cover property (take && i_rx_err && lq_change);
  c_refuse: cover property (take && i_rx_multi_seg);
  c_pend_served: cover property (take && s_reg.pend && i_rec_valid &&
    s_reg.pend_tag == tag);
endmodule

// *** lia_link_quality.sv ***
`timescale 1ns/1ps
// snr based link quality decision, any consistent estimator may sit here
module lia_link_quality #(
  parameter int SNR_W = lia_pkg::SNR_W,
  parameter logic [SNR_W-1:0] MARGIN = lia_pkg::SNR_MARGIN
) (
  // measurement
  input  wire logic [SNR_W-1:0] i_snr,
  input  wire logic [SNR_W-1:0] i_snr_need,
  input  wire logic i_ack,
  // decision
  output logic o_change
);
  import lia_pkg::*;
  logic [SNR_W:0] hi_bound;
  logic [SNR_W:0] lo_snr;
  // widened by one bit so the margin sum never wraps
  always_comb begin
    hi_bound = {1'b0, i_snr_need} + {1'b0, MARGIN};
    lo_snr = {1'b0, i_snr} + {1'b0, MARGIN};
    if (i_ack) begin
      o_change = ({1'b0, i_snr} > hi_bound); // R10
    end else begin
      o_change = (lo_snr < {1'b0, i_snr_need}); // R11
    end
  end
endmodule

// *** lia_pkg.sv ***
package lia_pkg;
  // ---------------------------------------------------------------
  // field layout of the acknowledgement data field
  // ---------------------------------------------------------------
  localparam int FIELD_W = 62;
  localparam int FT_LSB = 2;
  localparam logic [1:0] FT_IMM_ACK = 2'b01;
  localparam int RSV_A_LSB = 4;
  localparam int RSV_A_MSB = 5;
  localparam int TAG_LSB = 6;
  localparam int TAG_W = 6;
  localparam int SEQ_LSB = 12;
  localparam int SEQ_W = 8;
  localparam int UTC_BIT = 20;
  localparam int ACK_BIT = 21;
  localparam int TPR_LSB = 22;
  localparam int TPR_W = 4;
  localparam int RSV_B_LSB = 26;
  localparam int RSV_B_MSB = 28;
  localparam int LQ_BIT = 29;
  localparam int RSV_C_LSB = 30;
  localparam int RSV_C_MSB = 61;
  // recommendation sub-fields, relative to TPR_LSB
  localparam int TPR_RSCW = 0;
  localparam int TPR_REP_LSB = 1;
  localparam int TPR_INTM = 3;
  localparam logic [1:0] REP_NO_CHANGE = 2'b00;
  // ---------------------------------------------------------------
  // reset values and defaults
  // ---------------------------------------------------------------
  localparam logic [FIELD_W-1:0] FIELD_RST = 62'h0000_0000_0000_0000;
  localparam int NODE_IDENTIFIER_W = 12;
  localparam int SNR_W = 8;
  localparam logic [SNR_W-1:0] SNR_MARGIN = 8'h06;
  typedef enum logic {
    LIA_IDLE,
    LIA_HOLD
  } lia_state_e;
endpackage

// *** lia_remote_mac.sv ***
`timescale 1ns/1ps
// far-end mac: takes built fields and judges them as a sender would
module lia_remote_mac (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // field from the builder
  input wire logic i_valid,
  input wire logic [lia_pkg::FIELD_W-1:0] i_field,
  output logic o_ready,
  // control and expectation
  input wire logic [3:0] i_stall,
  input wire logic [5:0] i_exp_tag,
  input wire logic [7:0] i_exp_seq,
  // verdicts
  output logic o_got,
  output logic [lia_pkg::FIELD_W-1:0] o_fld,
  output logic o_acc,
  output logic o_resend,
  output logic o_match
);
  import lia_pkg::*;
  logic [3:0] wait_reg;
  // ready lags valid by the stall count, so slow takes are exercised
  always @(negedge i_core_clk) begin
    o_ready <= i_valid && (wait_reg >= i_stall);
  end
  // capture on the handshake edge only
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      wait_reg <= '0;
      o_got <= 1'b0;
      o_fld <= '0;
    end else begin
      o_got <= i_valid && o_ready;
      wait_reg <= (i_valid && !o_ready) ? wait_reg + 4'h1 : 4'h0;
      if (i_valid && o_ready) o_fld <= i_field;
    end
  end
  // ack only counts when no refusal is signalled
  assign o_acc = o_fld[ACK_BIT] && !o_fld[UTC_BIT];
  // a refusal asks for a resend in single-segment mode
  assign o_resend = o_fld[UTC_BIT];
  // frame identified by node tag plus sequence
  assign o_match = (o_fld[TAG_LSB +: TAG_W] == i_exp_tag) &&
    (o_fld[SEQ_LSB +: SEQ_W] == i_exp_seq);
endmodule

// *** low_complexity_imm_ack_field_builder_tb.sv ***
`timescale 1ns/1ps
module low_complexity_imm_ack_field_builder_tb;
  import lia_pkg::*;
  logic clk = 0, rst = 1, done = 0, rdy, err = 0, ms = 0, tpr = 0;
  logic rscw = 0, intm = 0, recv = 0, ack_rdy, remv = 0, got, acc, rsnd, mt;
  logic [11:0] nid = '0;
  logic [7:0] seq = '0, snr = '0, need = '0;
  logic [3:0] recval = '0, stall = '0;
  logic [61:0] remf = '0, fld, ackf;
  logic ackv, rv, rtok, rutc, rok, rnack, rlq;
  logic [5:0] rtag;
  logic [7:0] rseq;
  logic [3:0] rrec;
  int failures = 0, checks_done = 0;
  // ---------------------------------------------------------------
  // clock, instances
  // ---------------------------------------------------------------
  always #4 clk = ~clk;
  lia_ack_builder i_dut (.i_core_clk(clk), .i_rst(rst), .i_rx_done(done),
    .o_rx_ready(rdy), .i_rx_node_identifier(nid), .i_rx_llc_seq(seq),
    .i_rx_err(err), .i_rx_multi_seg(ms), .i_rx_tp_req(tpr),
    .i_rx_cur_rscw(rscw), .i_rx_cur_intm(intm), .i_rx_snr(snr),
    .i_rx_snr_need(need), .i_rec_valid(recv), .i_rec_value(recval),
    .o_ack_valid(ackv), .i_ack_ready(ack_rdy), .o_ack_field(ackf),
    .i_rem_valid(remv), .i_rem_field(remf), .o_rem_valid(rv),
    .o_rem_type_ok(rtok), .o_rem_tag(rtag), .o_rem_seq(rseq),
    .o_rem_utc(rutc), .o_rem_ack_ok(rok), .o_rem_nack(rnack),
    .o_rem_lq(rlq), .o_rem_rec(rrec));
  lia_remote_mac i_mac (.i_core_clk(clk), .i_rst(rst), .i_valid(ackv),
    .i_field(ackf), .o_ready(ack_rdy), .i_stall(stall),
    .i_exp_tag(nid[5:0]), .i_exp_seq(seq), .o_got(got), .o_fld(fld),
    .o_acc(acc), .o_resend(rsnd), .o_match(mt));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic bad(input string m);
    failures++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one received unit; expectation built from the field layout
  task automatic rx(input logic [3:0] er);
    logic [61:0] f;
    int n;
    f = '0;
    f[3:2] = 2'b01;
    f[11:6] = nid[5:0];
    f[19:12] = seq;
    f[20] = ms;
    f[21] = !err && !ms;
    f[25:22] = er;
    // sums taken as int so the margin cannot wrap
    f[29] = f[21] ? (int'(snr) > int'(need) + int'(SNR_MARGIN)) :
      (int'(snr) + int'(SNR_MARGIN) < int'(need));
    @(negedge clk) done = 1'b1;
    @(negedge clk) done = 1'b0;
    checks_done++;
    if (ackv !== 1'b1 || rdy !== 1'b0) bad("late answer");
    n = 0;
    while (got !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    checks_done++;
    if (n >= 20) begin
      bad("field never taken");
      close_out;
    end else if (fld !== f) begin
      bad("field mismatch");
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_ack;
    nid = 12'ha5c;
    seq = 8'h3c;
    snr = 8'd40;
    need = 8'd20;
    rscw = 1'b1;
    rx(4'h1);
    checks_done++;
    if (acc !== 1'b1 || mt !== 1'b1) bad("ack not matched");
    // exactly on the margin, so no change is recommended
    snr = 8'd26;
    intm = 1'b1;
    rscw = 1'b0;
    rx(4'h8);
  endtask
  task automatic s_nack;
    err = 1'b1;
    snr = 8'd13;
    need = 8'd20;
    stall = 4'h3;
    seq = 8'hff;
    rx(4'h8);
    checks_done++;
    if (acc !== 1'b0) bad("nack taken as ack");
    stall = 4'h0;
  endtask
  task automatic s_utc;
    err = 1'b0;
    ms = 1'b1;
    nid = 12'h0c3;
    seq = 8'h00;
    rx(4'h8);
    checks_done++;
    if (rsnd !== 1'b1 || mt !== 1'b1 || acc !== 1'b0) begin
      bad("refusal");
    end
    ms = 1'b0;
  endtask
  task automatic s_tp;
    intm = 1'b0;
    tpr = 1'b1;
    recv = 1'b1;
    recval = 4'h9;
    rx(4'h9);
    // no estimate: no-change now, report owed to this source
    recv = 1'b0;
    rx(4'h0);
    tpr = 1'b0;
    recv = 1'b1;
    recval = 4'h6;
    rx(4'h6);
    rx(4'h0);
    recv = 1'b0;
  endtask
  task automatic s_parse(input logic [61:0] v, input logic a, input logic n);
    @(negedge clk) begin
      remf = v;
      remv = 1'b1;
    end
    @(negedge clk) remv = 1'b0;
    checks_done++;
    if (rv !== 1'b1 || rtok !== 1'b1 || rtag !== 6'h3f) begin
      bad("parse head");
    end
    checks_done++;
    if (rok !== a || rnack !== n || rseq !== 8'hff) bad("parse ack");
    checks_done++;
    if (rutc !== v[20] || rlq !== v[29] || rrec !== v[25:22]) begin
      bad("parse flags");
    end
  endtask
  // reset in mid-run while a field waits for a slow taker
  task automatic s_reset;
    stall = 4'hf;
    @(negedge clk) done = 1'b1;
    @(negedge clk) begin
      done = 1'b0;
      rst = 1'b1;
    end
    repeat (2) @(negedge clk);
    rst = 1'b0;
    stall = 4'h0;
    checks_done++;
    if (ackv !== 1'b0 || rdy !== 1'b1 || ackf !== FIELD_RST) begin
      bad("reset left field");
    end
    checks_done++;
    if (rv !== 1'b0 || rtag !== 6'h00 || rseq !== 8'h00) bad("reset parse");
    rx(4'h0);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    checks_done++;
    if (rdy !== 1'b1 || ackv !== 1'b0 || ackf !== FIELD_RST) begin
      bad("reset");
    end
    s_ack();
    s_nack();
    s_utc();
    s_tp();
    s_parse(62'h3fff_ffff_ffff_fff7, 1'b0, 1'b0);
    s_parse(62'h3fff_ffff_ffcf_fff7, 1'b0, 1'b1);
    s_parse(62'h3fff_ffff_fd6f_fff7, 1'b1, 1'b0);
    s_reset();
    close_out();
  end
endmodule
